/* File: dv/mivc_irq_checker.sv */
// concurrent checks on the sequencer side of the interrupt controller
`timescale 1ns/1ps
module mivc_irq_checker (
  // clock and reset
  input logic clk,
  input logic resetn,
  // maskable request and acceptance
  input logic irqPending,
  input logic [mivc_pkg::NUM_W-1:0] irqNum,
  input logic [mivc_pkg::LVL_W-1:0] irqLevel,
  input logic irqAccept,
  input logic [mivc_pkg::SLOT_W-1:0] irqAcceptSlot,
  // traps and status word
  input logic trapReq,
  input logic trapValid,
  input logic irqEnable,
  input logic [mivc_pkg::LVL_W-1:0] cpuPriorityThreshold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // traps bypass every gate and clear the enable flag
  chk_trap_pulse: assert property (trapReq |=> trapValid && !irqEnable)
    else $error("trap request not answered");
  chk_trap_cause: assert property (trapValid |-> $past(trapReq))
    else $error("trap answer without request");
  // acceptance drops the request, the flag, and raises the threshold
  chk_accept_drop: assert property (irqAccept |=> !irqPending && !irqEnable)
    else $error("request still presented after acceptance");
  chk_accept_level: assert property (irqAccept && irqPending &&
    irqAcceptSlot == irqNum[4:0] |=> cpuPriorityThreshold == $past(irqLevel))
    else $error("threshold not loaded with accepted level");
  // pending is judged from the status word of the cycle before
  chk_enable_gate: assert property (irqPending |-> $past(irqEnable))
    else $error("request presented while disabled");
  chk_level_above: assert property (irqPending |-> irqLevel > $past(cpuPriorityThreshold))
    else $error("request level not above threshold");
  chk_level_zero: assert property (irqPending |-> irqLevel != 3'h0)
    else $error("level zero request presented");
  chk_num_range: assert property (irqPending |-> irqNum >= 6'h04 && irqNum <= 6'h1F)
    else $error("presented number outside maskable slots");
endmodule : mivc_irq_checker

bind mivc_irq_ctrl mivc_irq_checker mivc_irq_checker_inst (.*);

/* File: dv/mivc_seq_model.sv */
// behavioural cpu sequencer that accepts presented maskable requests
`timescale 1ns/1ps
module mivc_seq_model (
  // clock and reset
  input logic clk,
  input logic resetn,
  // request from the controller
  input logic irqPending,
  input logic [mivc_pkg::NUM_W-1:0] irqNum,
  // wait before acceptance, set by the bench
  input logic [1:0] delay,
  // acceptance
  output logic irqAccept,
  output logic [mivc_pkg::SLOT_W-1:0] irqAcceptSlot
);
  logic [1:0] waitCnt;
  // one pulse per request; idle slot lines toggle so no stale number looks valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqAccept <= 1'b0;
      irqAcceptSlot <= 5'h1F;
      waitCnt <= 2'h0;
    end else begin
      irqAccept <= 1'b0;
      irqAcceptSlot <= ~irqAcceptSlot;
      if (!irqPending || irqAccept) waitCnt <= 2'h0;
      else if (waitCnt < delay) waitCnt <= waitCnt + 2'h1;
      else begin
        irqAccept <= 1'b1;
        irqAcceptSlot <= irqNum[4:0];
      end
    end
  end
endmodule : mivc_seq_model

/* File: dv/tb_top.sv */
// self-checking bench for the maskable interrupt vector controller
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // signals, tables and helpers
  // ****************************************************************
  logic clk = 1'b0, resetn = 1'b0, serial2I2cMode = 1'b0, trapReq = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, base, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, delay = '0;
  logic [33:0] src = '0;
  logic irqPending, irqAccept, trapValid, irqEnable;
  logic [5:0] trapNum = '0, irqNum;
  logic [2:0] irqLevel, cpuPriorityThreshold;
  logic [19:0] irqVector, trapVector;
  logic [4:0] irqAcceptSlot;
  int badCount = 0, comparisons = 0, seed = 32'h2cf1, cycles = 0;
  // slot of each source bit, and the select or mode bit that routes it
  localparam int SLOT [34] = '{26, 27, 28, 7, 6, 5, 21, 22, 23, 24, 25, 17, 19, 15, 18, 20, 16,
    29, 30, 31, 4, 24, 25, 9, 8, 31, 4, 10, 11, 12, 13, 14, 15, 16};
  localparam int GC [34] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 3, 5, 0, 0, 9, 0, 0, 9,
    0, 0, 7, 1, 4, 6, 0, 0, 8, 2, 0, 0, 0, 0, 0, 10, 10};
  localparam int TRAPS [5] = '{0, 1, 31, 32, 63};
  mivc_irq_ctrl mivc_irq_ctrl_inst (.*, .typeBCounterIrq(src[5:0]), .typeACounterIrq(src[10:6]),
    .asyncSerialTxIrq(src[13:11]), .asyncSerialRxIrq(src[16:14]), .extPinIrq(src[24:17]),
    .auxSerial3Irq(src[25]), .auxSerial4Irq(src[26]), .busCollisionIrq(src[27]),
    .transferChannelIrq(src[29:28]), .keyInputIrq(src[30]), .adcIrq(src[31]),
    .i2cNackIrq(src[32]), .i2cAckIrq(src[33]));
  mivc_seq_model mivc_seq_model_inst (.*);
  always #2 clk = ~clk;
  // about 60 short tests of under 60 cycles each; far above that means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      summarize();
    end
  end
  function automatic bit routed(int b, int cv);
    int g = GC[b];
    return g == 0 || cv[(g - 1) / 2] == (g - 1) % 2;
  endfunction : routed
  function automatic logic [31:0] vec(int n);
    return (base + 4 * n) & 32'hFFFFF;
  endfunction : vec
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // ready and answer are looked at mid-cycle, acted on at the next edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bit aw, w, b;
    logic [1:0] resp;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      #1;
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    check("write response", mivc_pkg::RESP_OKAY, resp);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    bit ar, r;
    logic [1:0] resp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      #1;
      ar = s_axi_arready;
      r = s_axi_rvalid;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    check("read response", mivc_pkg::RESP_OKAY, resp);
  endtask : rd
  task automatic summarize();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  initial begin
    int b, lvl, thr, en, cv;
    bit hit;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(mivc_pkg::STATUS_OFS, d);
    check("status at reset", 0, d);
    rd(mivc_pkg::VTB_OFS, d);
    check("base at reset", 0, d);
    rd(12'h0F0, d);
    check("unmapped read", 0, d);
    base = $random(seed) & 32'hFFFFF;
    wr(mivc_pkg::VTB_OFS, base);
    // traps with the enable flag still clear
    foreach (TRAPS[i]) begin
      trapReq <= 1'b1;
      trapNum <= TRAPS[i];
      @(posedge clk);
      trapReq <= 1'b0;
      #1;
      check("trap valid", 1, trapValid);
      check("trap vector", vec(TRAPS[i]), trapVector);
      @(posedge clk);
    end
    $display("trap test done");
    // one source, random route, level, threshold and enable
    for (int t = 0; t < 60; t++) begin
      b = {$random(seed)} % 34;
      cv = {$random(seed)} % 32;
      lvl = {$random(seed)} % 8;
      thr = {$random(seed)} % 8;
      en = ({$random(seed)} % 4) != 0;
      hit = routed(b, cv) && en && lvl > thr;
      delay <= $random(seed);
      serial2I2cMode <= cv[4];
      wr(mivc_pkg::CAUSE_SEL_OFS, (cv % 16) << 4);
      wr(mivc_pkg::CTRL_BASE_OFS + 4 * SLOT[b], lvl);
      wr(mivc_pkg::STATUS_OFS, (thr << 4) | en);
      src[b] <= 1'b1;
      @(posedge clk);
      src[b] <= 1'b0;
      // look mid-cycle only, never in the edge's own time step
      repeat (4) begin
        @(posedge clk);
        #1;
        if (irqPending) break;
      end
      check("pending", hit, irqPending);
      if (hit) begin
        check("number", SLOT[b], irqNum);
        check("level", lvl, irqLevel);
        check("vector", vec(SLOT[b]), irqVector);
        repeat (6) @(posedge clk);
        #1;
        check("threshold", lvl, cpuPriorityThreshold);
        check("enable", 0, irqEnable);
      end
      @(posedge clk); // bus requests start right after an edge
      rd(mivc_pkg::CTRL_BASE_OFS + 4 * SLOT[b], d);
      check("request bit", routed(b, cv) && !hit, d[3]);
      wr(mivc_pkg::CTRL_BASE_OFS + 4 * SLOT[b], lvl);
      rd(mivc_pkg::CTRL_BASE_OFS + 4 * SLOT[b], d);
      check("cleared control", lvl, d);
      $display("source test %0d done", t);
    end
    // two sources together: higher level wins although its slot is higher
    wr(mivc_pkg::CTRL_BASE_OFS + 32, 3);
    wr(mivc_pkg::CTRL_BASE_OFS + 40, 5);
    wr(mivc_pkg::STATUS_OFS, 1);
    src <= 34'h009000000;
    @(posedge clk);
    src <= '0;
    @(posedge clk);
    #1;
    check("winner number", 10, irqNum);
    check("winner level", 5, irqLevel);
    $display("priority test done");
    summarize();
  end
endmodule : tb_top

/* File: hw/mivc_axil_slave.sv */
// AXI4-Lite front end producing a one-cycle register write strobe and a held read address
`timescale 1ns/1ps
module mivc_axil_slave (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write address and data
  input wire logic [mivc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [mivc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [mivc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [mivc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output logic wrStrobe,
  output logic [mivc_pkg::ADDR_W-1:0] wrAddr,
  output logic [mivc_pkg::DATA_W-1:0] wrData,
  output logic [3:0] wrStrb,
  output logic [mivc_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [mivc_pkg::DATA_W-1:0] rdData
);

  logic awGot_reg;
  logic wGot_reg;
  logic rdPend_reg;

  // write fires once both halves are in and no response is outstanding
  assign wrStrobe = awGot_reg & wGot_reg & ~s_axi_bvalid;
  assign s_axi_bresp = mivc_pkg::RESP_OKAY;
  assign s_axi_rresp = mivc_pkg::RESP_OKAY;

  // address and data captured independently, in either order
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awGot_reg <= 1'b0;
      wGot_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wrAddr <= s_axi_awaddr;
        awGot_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        wGot_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrStrobe) begin
        awGot_reg <= 1'b0;
        wGot_reg <= 1'b0;
      end
      // ready again only after the response is taken: one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wrStrobe) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read: capture address, sample register mux one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      rdPend_reg <= 1'b0;
      rdAddr <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rdAddr <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rdPend_reg <= 1'b1;
      end
      if (rdPend_reg) begin
        s_axi_rdata <= rdData;
        s_axi_rvalid <= 1'b1;
        rdPend_reg <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : mivc_axil_slave

/* File: hw/mivc_irq_ctrl.sv */
// maskable interrupt vectoring, per-source control and cpu status word
`timescale 1ns/1ps
module mivc_irq_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite register bus
  input wire logic [mivc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [mivc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mivc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [mivc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral request pulses, same clock
  input wire logic [5:0] typeBCounterIrq,
  input wire logic [4:0] typeACounterIrq,
  input wire logic [2:0] asyncSerialTxIrq,
  input wire logic [2:0] asyncSerialRxIrq,
  input wire logic [7:0] extPinIrq,
  input wire logic auxSerial3Irq,
  input wire logic auxSerial4Irq,
  input wire logic busCollisionIrq,
  input wire logic [1:0] transferChannelIrq,
  input wire logic keyInputIrq,
  input wire logic adcIrq,
  input wire logic i2cNackIrq,
  input wire logic i2cAckIrq,
  input wire logic serial2I2cMode,
  // cpu sequencer: maskable request and acceptance
  output logic irqPending,
  output logic [mivc_pkg::NUM_W-1:0] irqNum,
  output logic [mivc_pkg::LVL_W-1:0] irqLevel,
  output logic [mivc_pkg::CPU_ADDR_W-1:0] irqVector,
  input wire logic irqAccept,
  input wire logic [mivc_pkg::SLOT_W-1:0] irqAcceptSlot,
  // cpu sequencer: instruction traps
  input wire logic trapReq,
  input wire logic [mivc_pkg::NUM_W-1:0] trapNum,
  output logic trapValid,
  output logic [mivc_pkg::CPU_ADDR_W-1:0] trapVector,
  // cpu status word view
  output logic irqEnable,
  output logic [mivc_pkg::LVL_W-1:0] cpuPriorityThreshold
);

  localparam int N = mivc_pkg::NUM_HW_SLOTS;
  localparam int LW = mivc_pkg::LVL_W;

  // ***************************************************************
  // register bus
  // ***************************************************************
  logic wrStrobe;
  logic [mivc_pkg::ADDR_W-1:0] wrAddr;
  logic [mivc_pkg::DATA_W-1:0] wrData;
  logic [3:0] wrStrb;
  logic [mivc_pkg::ADDR_W-1:0] rdAddr;
  logic [mivc_pkg::DATA_W-1:0] rdData;

  mivc_axil_slave u_bus (
    .clk(clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  logic wrVtb;
  logic wrStatus;
  logic wrCause;
  logic wrCtrlHit;
  logic [mivc_pkg::SLOT_W-1:0] wrSlot;

  // decode; control block spans 32 words from its base
  assign wrVtb = wrStrobe && (wrAddr == mivc_pkg::VTB_OFS);
  assign wrStatus = wrStrobe && (wrAddr == mivc_pkg::STATUS_OFS);
  assign wrCause = wrStrobe && (wrAddr == mivc_pkg::CAUSE_SEL_OFS);
  assign wrCtrlHit = wrStrobe && (wrAddr[11:7] == mivc_pkg::CTRL_BASE_OFS[11:7]);
  assign wrSlot = wrAddr[6:2];

  // ***************************************************************
  // vector table base and cause select
  // ***************************************************************
  logic [mivc_pkg::CPU_ADDR_W-1:0] vectorTableBase_reg;
  logic [3:0] causeSel_reg;
  logic [31:0] vtbMerged;
  logic [31:0] causeMerged;

  assign vtbMerged = mergeBytes({12'h000, vectorTableBase_reg}, wrData, wrStrb);
  assign causeMerged = mergeBytes({24'h000000, causeSel_reg, 4'h0}, wrData, wrStrb);

  // base is loaded by software before interrupts are enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vectorTableBase_reg <= mivc_pkg::VTB_RESET;
    end else if (wrVtb) begin
      vectorTableBase_reg <= vtbMerged[mivc_pkg::CPU_ADDR_W-1:0];
    end
  end

  // cause-select bits for the four shared slots
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      causeSel_reg <= mivc_pkg::CAUSE_SEL_RESET;
    end else if (wrCause) begin
      causeSel_reg <= causeMerged[mivc_pkg::CAUSE_SEL_LSB +: 4];
    end
  end

  // ***************************************************************
  // slot map
  // ***************************************************************
  logic [N-1:0] slotEvent;

  // one source per slot, switchable on slots 4, 15, 16, 24, 25 and 31; slots 0..3 carry no hardware source
  always_comb begin
    slotEvent = '0;
    slotEvent[mivc_pkg::SLOT_SHARED_4] = causeSel_reg[0] ? auxSerial4Irq : extPinIrq[3];
    for (int k = 0; k < 3; k++) begin
      slotEvent[mivc_pkg::SLOT_TB5 + k] = typeBCounterIrq[5 - k];
      slotEvent[mivc_pkg::SLOT_TB0 + k] = typeBCounterIrq[k];
    end
    for (int k = 0; k < 5; k++) begin
      slotEvent[mivc_pkg::SLOT_TA0 + k] = typeACounterIrq[k];
    end
    slotEvent[mivc_pkg::SLOT_PIN7] = extPinIrq[7];
    slotEvent[mivc_pkg::SLOT_PIN6] = extPinIrq[6];
    slotEvent[mivc_pkg::SLOT_BUS_COLL] = busCollisionIrq;
    slotEvent[mivc_pkg::SLOT_XFER0] = transferChannelIrq[0];
    slotEvent[mivc_pkg::SLOT_XFER0 + 1] = transferChannelIrq[1];
    slotEvent[mivc_pkg::SLOT_KEY] = keyInputIrq;
    slotEvent[mivc_pkg::SLOT_ADC] = adcIrq;
    // I2C mode swaps the serial 2 events for the acknowledge events
    slotEvent[mivc_pkg::SLOT_S2_TX] = serial2I2cMode ? i2cNackIrq : asyncSerialTxIrq[2];
    slotEvent[mivc_pkg::SLOT_S2_RX] = serial2I2cMode ? i2cAckIrq : asyncSerialRxIrq[2];
    for (int k = 0; k < 2; k++) begin
      slotEvent[mivc_pkg::SLOT_S0_TX + 2 * k] = asyncSerialTxIrq[k];
      slotEvent[mivc_pkg::SLOT_S0_TX + 2 * k + 1] = asyncSerialRxIrq[k];
    end
    // type_a_counter_3/A4 default, pins 4/5 when the select bit is set
    slotEvent[mivc_pkg::SLOT_SHARED_24] = causeSel_reg[1] ? extPinIrq[4] : typeACounterIrq[3];
    slotEvent[mivc_pkg::SLOT_SHARED_25] = causeSel_reg[2] ? extPinIrq[5] : typeACounterIrq[4];
    slotEvent[mivc_pkg::SLOT_PIN0] = extPinIrq[0];
    slotEvent[mivc_pkg::SLOT_PIN1] = extPinIrq[1];
    slotEvent[mivc_pkg::SLOT_SHARED_31] = causeSel_reg[3] ? auxSerial3Irq : extPinIrq[2];
  end

  // ***************************************************************
  // per-source control registers
  // ***************************************************************
  wire [N-1:0] reqVec;
  wire [N*LW-1:0] levelVec;

  for (genvar n = 0; n < N; n++) begin : g_slot
    if (n >= mivc_pkg::FIRST_MASKABLE) begin : g_mask
      logic req_reg;
      logic [LW-1:0] level_reg;
      logic wrHere;
      logic [31:0] merged;
      assign wrHere = wrCtrlHit && (wrSlot == mivc_pkg::SLOT_W'(n));
      assign merged = mergeBytes({28'h0000000, req_reg, level_reg}, wrData, wrStrb);

      // set beats both clears in the same cycle, so no event is lost
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          req_reg <= 1'b0;
        end else if (slotEvent[n]) begin
          req_reg <= 1'b1;
        end else if (irqAccept && (irqAcceptSlot == mivc_pkg::SLOT_W'(n))) begin
          req_reg <= 1'b0;
        end else if (wrHere && !merged[mivc_pkg::CTRL_REQ_BIT]) begin
          req_reg <= 1'b0;
        end
      end

      // priority level field of this source
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          level_reg <= mivc_pkg::LVL_RESET;
        end else if (wrHere) begin
          level_reg <= merged[mivc_pkg::CTRL_LVL_LSB +: LW];
        end
      end
      assign reqVec[n] = req_reg;
      assign levelVec[n*LW +: LW] = level_reg;
    end else begin : g_none
      assign reqVec[n] = 1'b0;
      assign levelVec[n*LW +: LW] = '0;
    end
  end

  // ***************************************************************
  // cpu status word: enable flag and priority threshold
  // ***************************************************************
  logic iFlag_reg;
  logic [LW-1:0] ipl_reg;
  logic [31:0] statusMerged;
  logic [LW-1:0] acceptLevel;

  assign statusMerged = mergeBytes({25'h0000000, ipl_reg, 3'h0, iFlag_reg}, wrData, wrStrb);
  assign acceptLevel = levelVec[irqAcceptSlot*LW +: LW];

  // acceptance and traps override a software write in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      iFlag_reg <= 1'b0;
      ipl_reg <= mivc_pkg::IPL_RESET;
    end else if (irqAccept) begin
      iFlag_reg <= 1'b0;
      ipl_reg <= acceptLevel;
    end else if (trapReq) begin
      iFlag_reg <= 1'b0;
    end else if (wrStatus) begin
      iFlag_reg <= statusMerged[mivc_pkg::STATUS_I_BIT];
      ipl_reg <= statusMerged[mivc_pkg::STATUS_IPL_LSB +: LW];
    end
  end

  // ***************************************************************
  // arbitration and cpu-facing outputs
  // ***************************************************************
  logic found;
  logic [mivc_pkg::SLOT_W-1:0] winSlot;
  logic [LW-1:0] winLevel;

  // gating applies to maskable slots only; traps never pass through here
  mivc_prio_arbiter #(
    .NUM_SLOTS(N),
    .SLOT_W(mivc_pkg::SLOT_W)
  ) u_arb (
    .reqVec(reqVec),
    .levelVec(levelVec),
    .enable(iFlag_reg),
    .threshold(ipl_reg),
    .found(found),
    .winSlot(winSlot),
    .winLevel(winLevel)
  );

  // presented request drops at the edge that ends the accept cycle to avoid a stale retake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqPending <= 1'b0;
      irqNum <= '0;
      irqLevel <= '0;
      irqVector <= '0;
    end else begin
      irqPending <= found && !irqAccept;
      irqNum <= {1'b0, winSlot};
      irqLevel <= winLevel;
      irqVector <= vectorTableBase_reg + {13'h0000, winSlot, 2'b00};
    end
  end

  // traps bypass enable flag and threshold entirely
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trapValid <= 1'b0;
      trapVector <= '0;
    end else begin
      trapValid <= trapReq;
      if (trapReq) begin
        trapVector <= vectorTableBase_reg + {12'h000, trapNum, 2'b00};
      end
    end
  end

  assign irqEnable = iFlag_reg;
  assign cpuPriorityThreshold = ipl_reg;

  // register read mux; unmapped addresses read zero
  always_comb begin
    rdData = '0;
    if (rdAddr == mivc_pkg::VTB_OFS) begin
      rdData = {12'h000, vectorTableBase_reg};
    end else if (rdAddr == mivc_pkg::STATUS_OFS) begin
      rdData = {25'h0000000, ipl_reg, 3'h0, iFlag_reg};
    end else if (rdAddr == mivc_pkg::CAUSE_SEL_OFS) begin
      rdData = {24'h000000, causeSel_reg, 4'h0};
    end else if (rdAddr[11:7] == mivc_pkg::CTRL_BASE_OFS[11:7]) begin
      rdData = {28'h0000000, reqVec[rdAddr[6:2]], levelVec[rdAddr[6:2]*LW +: LW]};
    end
  end

endmodule : mivc_irq_ctrl

/* File: hw/mivc_pkg.sv */
// constants, offsets and field layout of the maskable interrupt vector controller
package mivc_pkg;

  // ***************************************************************
  // bus and address layout
  // ***************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CPU_ADDR_W = 20;
  localparam logic [ADDR_W-1:0] VTB_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] CTRL_BASE_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] CAUSE_SEL_IDX = 12'h35F;
  localparam logic [ADDR_W-1:0] CAUSE_SEL_OFS = {CAUSE_SEL_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int CTRL_LVL_LSB = 0;
  localparam int CTRL_REQ_BIT = 3;
  localparam int STATUS_I_BIT = 0;
  localparam int STATUS_IPL_LSB = 4;
  localparam int CAUSE_SEL_LSB = 4;
  localparam int LVL_W = 3;
  localparam logic [CPU_ADDR_W-1:0] VTB_RESET = 20'h00000;
  localparam logic [LVL_W-1:0] LVL_RESET = 3'h0;
  localparam logic [LVL_W-1:0] IPL_RESET = 3'h0;
  localparam logic [3:0] CAUSE_SEL_RESET = 4'h0;

  // ***************************************************************
  // vector table geometry and slot numbers
  // ***************************************************************
  localparam int VEC_TABLE_BYTES = 256;
  localparam int VEC_BYTES = 4;
  localparam int NUM_VECTORS = VEC_TABLE_BYTES / VEC_BYTES;
  localparam int NUM_HW_SLOTS = 32;
  localparam int FIRST_MASKABLE = 4;
  localparam int NUM_W = 6;
  localparam int SLOT_W = 5;
  localparam int SLOT_SHARED_4 = 4;
  localparam int SLOT_TB5 = 5;
  localparam int SLOT_PIN7 = 8;
  localparam int SLOT_PIN6 = 9;
  localparam int SLOT_BUS_COLL = 10;
  localparam int SLOT_XFER0 = 11;
  localparam int SLOT_KEY = 13;
  localparam int SLOT_ADC = 14;
  localparam int SLOT_S2_TX = 15;
  localparam int SLOT_S2_RX = 16;
  localparam int SLOT_S0_TX = 17;
  localparam int SLOT_TA0 = 21;
  localparam int SLOT_SHARED_24 = 24;
  localparam int SLOT_SHARED_25 = 25;
  localparam int SLOT_TB0 = 26;
  localparam int SLOT_PIN0 = 29;
  localparam int SLOT_PIN1 = 30;
  localparam int SLOT_SHARED_31 = 31;

endpackage : mivc_pkg

/* File: hw/mivc_prio_arbiter.sv */
// combinational search for the highest acceptable maskable request
`timescale 1ns/1ps
module mivc_prio_arbiter #(
  parameter int NUM_SLOTS = 32,
  parameter int SLOT_W = 5
) (
  // candidates
  input wire logic [NUM_SLOTS-1:0] reqVec,
  input wire logic [NUM_SLOTS*mivc_pkg::LVL_W-1:0] levelVec,
  // gating from the cpu status word
  input wire logic enable,
  input wire logic [mivc_pkg::LVL_W-1:0] threshold,
  // winner
  output logic found,
  output logic [SLOT_W-1:0] winSlot,
  output logic [mivc_pkg::LVL_W-1:0] winLevel
);

  // slot index must fit the winner field
  if ((1 << SLOT_W) < NUM_SLOTS) begin : g_bad_width
    $error("mivc_prio_arbiter: SLOT_W too small for NUM_SLOTS");
  end

  // strict compare from the threshold upward; ascending scan keeps lowest slot on ties
  always_comb begin
    logic [mivc_pkg::LVL_W-1:0] lvl;
    lvl = '0;
    found = 1'b0;
    winSlot = '0;
    winLevel = threshold;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      lvl = levelVec[i*mivc_pkg::LVL_W +: mivc_pkg::LVL_W];
      if (enable && reqVec[i] && (lvl > winLevel)) begin
        found = 1'b1;
        winSlot = SLOT_W'(i);
        winLevel = lvl;
      end
    end
  end

endmodule : mivc_prio_arbiter
